/* logic/gpa_port.sv */
// Purpose: Port A pin control registers and pin interrupt logic.
// Assumes: Plain register port, read data one cycle after the read strobe.
// Notes: Pad controls are registered outputs.
//
// Chosen here: the plain strobed port and the register addresses.

`timescale 1ns/1ps
`default_nettype none

module gpa_port
   import gpa_pkg::*;
#(
   parameter int NPIN = gpa_pkg::GPA_NPIN
) (
   // Clock and reset.
   input wire logic mclk_i,
   input wire logic resetn_i,
   // Register port.
   input wire logic [gpa_pkg::GPA_AW-1:0] addr_i,
   input wire logic [gpa_pkg::GPA_DW-1:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [gpa_pkg::GPA_DW-1:0] rdata_o,
   // Pins.
   input wire logic [NPIN-1:0] pin_in_i,
   output logic [NPIN-1:0] pin_out_o,
   output logic [NPIN-1:0] pin_oe_o,
   output logic [NPIN-1:0] pull_en_o,
   output logic [NPIN-1:0] pull_up_o,
   output logic [NPIN-1:0] slew_en_o,
   output logic [NPIN-1:0] drive_high_o,
   // Interrupts.
   output logic pin_irq_o,
   output logic irq_o
);

   import gpa_pkg::*;

   if (NPIN != GPA_NPIN) begin : gen_npin_check
      $error("Only four pins are supported.");
   end

   // ------------------------------------------------------------
   // Register storage.
   // ------------------------------------------------------------
   logic [NPIN-1:0] data_bits;
   logic [NPIN-1:0] direction_bits;
   logic [NPIN-1:0] pull_enable_bits;
   logic [NPIN-1:0] slew_enable_bits;
   logic [NPIN-1:0] drive_strength_bits;
   logic [NPIN-1:0] irq_pin_select_bits;
   logic [NPIN-1:0] edge_polarity_select_bits;
   logic pin_irq_flag;
   logic pin_irq_request_enable;
   logic detect_mode_select;
   logic [GPA_NEV-1:0] ev_status;
   logic [GPA_NEV-1:0] ev_mask;

   // ------------------------------------------------------------
   // Write decode.
   // ------------------------------------------------------------
   function automatic logic hit(input logic [GPA_AW-1:0] a, input logic [GPA_AW-1:0] off);
      hit = (a == off);
   endfunction

   wire wr_data = wr_i && hit(addr_i, GPA_OFF_DATA);
   wire wr_dir = wr_i && hit(addr_i, GPA_OFF_DIR);
   wire wr_pull = wr_i && hit(addr_i, GPA_OFF_PULL);
   wire wr_slew = wr_i && hit(addr_i, GPA_OFF_SLEW);
   wire wr_drive = wr_i && hit(addr_i, GPA_OFF_DRIVE);
   wire wr_sc = wr_i && hit(addr_i, GPA_OFF_SC);
   wire wr_psel = wr_i && hit(addr_i, GPA_OFF_PSEL);
   wire wr_pol = wr_i && hit(addr_i, GPA_OFF_POL);
   wire wr_ist = wr_i && hit(addr_i, GPA_OFF_IST);
   wire wr_imsk = wr_i && hit(addr_i, GPA_OFF_IMSK);
   wire [NPIN-1:0] wlow = wdata_i[NPIN-1:0];

   // ------------------------------------------------------------
   // Pin detection.
   // ------------------------------------------------------------
   logic [NPIN-1:0] pin_edge;
   logic [NPIN-1:0] pin_level;
   logic [NPIN-1:0] pin_sync;

   gpa_pin_detect #(
      .NPIN(NPIN)
   ) u_detect (
      .mclk_i(mclk_i),
      .resetn_i(resetn_i),
      .pin_i(pin_in_i),
      .polarity_i(edge_polarity_select_bits),
      .enable_i(irq_pin_select_bits),
      .edge_o(pin_edge),
      .level_o(pin_level)
   );

   // Second synchroniser for the data readback of input pins.
   logic [NPIN-1:0] rd_sync1;
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rd_sync1 <= GPA_RST_PIN;
         pin_sync <= GPA_RST_PIN;
      end else begin
         rd_sync1 <= pin_in_i;
         pin_sync <= rd_sync1;
      end
   end

   // ------------------------------------------------------------
   // Interrupt flag logic.
   // ------------------------------------------------------------
   wire any_edge = |pin_edge;
   wire any_level = |pin_level;
   wire detect = any_edge || (detect_mode_select && any_level);
   wire ack = wr_sc && wdata_i[GPA_SC_ACK];
   wire ack_blocked = detect_mode_select && any_level;
   wire next_flag = detect ? 1'b1 : ((ack && !ack_blocked) ? 1'b0 : pin_irq_flag);
   wire ack_fail = ack && ack_blocked;

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pin_irq_flag <= 1'b0;
         pin_irq_request_enable <= 1'b0;
         detect_mode_select <= 1'b0;
      end else begin
         pin_irq_flag <= next_flag;
         if (wr_sc) begin
            pin_irq_request_enable <= wdata_i[GPA_SC_IE];
            detect_mode_select <= wdata_i[GPA_SC_MOD];
         end
      end
   end

   // ------------------------------------------------------------
   // Sticky event status with mask.
   // ------------------------------------------------------------
   wire [GPA_NEV-1:0] ev_set = {ack_fail, detect};
   wire [GPA_NEV-1:0] ev_clr = wr_ist ? wdata_i[GPA_NEV-1:0] : GPA_RST_EV;
   wire [GPA_NEV-1:0] next_ev = ev_set | (ev_status & ~ev_clr);

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ev_status <= GPA_RST_EV;
         ev_mask <= GPA_RST_EV;
      end else begin
         ev_status <= next_ev;
         if (wr_imsk) begin
            ev_mask <= wdata_i[GPA_NEV-1:0];
         end
      end
   end

   // ------------------------------------------------------------
   // Control registers.
   // ------------------------------------------------------------
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         data_bits <= GPA_RST_PIN;
         direction_bits <= GPA_RST_PIN;
         pull_enable_bits <= GPA_RST_PIN;
         slew_enable_bits <= GPA_RST_PIN;
         drive_strength_bits <= GPA_RST_PIN;
         irq_pin_select_bits <= GPA_RST_PIN;
         edge_polarity_select_bits <= GPA_RST_PIN;
      end else begin
         if (wr_data) begin
            data_bits <= wlow;
         end
         if (wr_dir) begin
            direction_bits <= wlow;
         end
         if (wr_pull) begin
            pull_enable_bits <= wlow;
         end
         if (wr_slew) begin
            slew_enable_bits <= wlow;
         end
         if (wr_drive) begin
            drive_strength_bits <= wlow;
         end
         if (wr_psel) begin
            irq_pin_select_bits <= wlow;
         end
         if (wr_pol) begin
            edge_polarity_select_bits <= wlow;
         end
      end
   end

   // ------------------------------------------------------------
   // Pad control outputs.
   // ------------------------------------------------------------
   wire [NPIN-1:0] next_oe = direction_bits;
   wire [NPIN-1:0] next_pull = pull_enable_bits & ~direction_bits;
   wire [NPIN-1:0] next_pull_up = ~edge_polarity_select_bits;
   wire [NPIN-1:0] next_slew = slew_enable_bits & direction_bits;
   wire [NPIN-1:0] next_drive = drive_strength_bits & direction_bits;
   wire next_pin_irq = pin_irq_flag && pin_irq_request_enable;
   wire next_irq = |(ev_status & ev_mask);

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pin_out_o <= GPA_RST_PIN;
         pin_oe_o <= GPA_RST_PIN;
         pull_en_o <= GPA_RST_PIN;
         pull_up_o <= GPA_RST_PIN;
         slew_en_o <= GPA_RST_PIN;
         drive_high_o <= GPA_RST_PIN;
         pin_irq_o <= 1'b0;
         irq_o <= 1'b0;
      end else begin
         pin_out_o <= data_bits;
         pin_oe_o <= next_oe;
         pull_en_o <= next_pull;
         pull_up_o <= next_pull_up;
         slew_en_o <= next_slew;
         drive_high_o <= next_drive;
         pin_irq_o <= next_pin_irq;
         irq_o <= next_irq;
      end
   end

   // ------------------------------------------------------------
   // Read multiplexer.
   // ------------------------------------------------------------
   wire [NPIN-1:0] data_rd = (direction_bits & data_bits) | (~direction_bits & pin_sync);
   wire [GPA_DW-1:0] sc_rd = {4'h0, pin_irq_flag, 1'b0, pin_irq_request_enable,
                              detect_mode_select};
   wire [GPA_DW-1:0] rd_sel =
      hit(addr_i, GPA_OFF_DATA) ? {4'h0, data_rd} :
      hit(addr_i, GPA_OFF_DIR) ? {4'h0, direction_bits} :
      hit(addr_i, GPA_OFF_PULL) ? {4'h0, pull_enable_bits} :
      hit(addr_i, GPA_OFF_SLEW) ? {4'h0, slew_enable_bits} :
      hit(addr_i, GPA_OFF_DRIVE) ? {4'h0, drive_strength_bits} :
      hit(addr_i, GPA_OFF_SC) ? sc_rd :
      hit(addr_i, GPA_OFF_PSEL) ? {4'h0, irq_pin_select_bits} :
      hit(addr_i, GPA_OFF_POL) ? {4'h0, edge_polarity_select_bits} :
      hit(addr_i, GPA_OFF_IST) ? {6'h00, ev_status} :
      hit(addr_i, GPA_OFF_IMSK) ? {6'h00, ev_mask} :
      GPA_RD_ZERO;

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rdata_o <= GPA_RD_ZERO;
      end else begin
         rdata_o <= rd_i ? rd_sel : GPA_RD_ZERO;
      end
   end

endmodule

`default_nettype wire

/* logic/gpa_pkg.sv */
// Purpose: Constants for the port A pin control and pin interrupt block.
// Assumes: Byte-wide registers on a plain strobe port, one clock, active-low reset.
// Notes: Offsets are register indices on the local port.
//
// Operation
// - Set pull bit enables pin pull device.
// - Output pins keep pull device disabled.
// - Slew bit enables slew control on outputs.
// - Drive bit selects high or low drive.
// - Bits 7 to 4 unimplemented, ignored.
// - Hardware sets read-only interrupt flag bit 3.
// - Acknowledge write clears flag, reads zero.
// - Interrupt enable gates the request.
// - Mode bit: edges only or edges and levels.
// - Pin select bit makes pin a source.
// - Polarity bit picks pull direction and edge.
// - Level mode clear only when pins deasserted.
// - Direction bit one enables output driver.

package gpa_pkg;

   localparam int GPA_NPIN = 4;
   localparam int GPA_AW = 4;
   localparam int GPA_DW = 8;

   // ------------------------------------------------------------
   // Register offsets.
   // ------------------------------------------------------------
   localparam logic [3:0] GPA_OFF_DATA = 4'h0;
   localparam logic [3:0] GPA_OFF_DIR = 4'h1;
   localparam logic [3:0] GPA_OFF_PULL = 4'h2;
   localparam logic [3:0] GPA_OFF_SLEW = 4'h3;
   localparam logic [3:0] GPA_OFF_DRIVE = 4'h4;
   localparam logic [3:0] GPA_OFF_SC = 4'h5;
   localparam logic [3:0] GPA_OFF_PSEL = 4'h6;
   localparam logic [3:0] GPA_OFF_POL = 4'h7;
   localparam logic [3:0] GPA_OFF_IST = 4'h8;
   localparam logic [3:0] GPA_OFF_IMSK = 4'h9;

   // ------------------------------------------------------------
   // Field positions of the status and control register.
   // ------------------------------------------------------------
   localparam int GPA_SC_FLAG = 3;
   localparam int GPA_SC_ACK = 2;
   localparam int GPA_SC_IE = 1;
   localparam int GPA_SC_MOD = 0;

   // ------------------------------------------------------------
   // Field positions of the sticky event status register.
   // ------------------------------------------------------------
   localparam int GPA_EV_DETECT = 0;
   localparam int GPA_EV_ACKFAIL = 1;
   localparam int GPA_NEV = 2;

   // ------------------------------------------------------------
   // Reset values.
   // ------------------------------------------------------------
   localparam logic [3:0] GPA_RST_PIN = 4'h0;
   localparam logic [1:0] GPA_RST_EV = 2'h0;
   localparam logic [7:0] GPA_RD_ZERO = 8'h00;

endpackage

/* logic/gpa_pin_detect.sv */
// Purpose: Synchronises the pins and finds active edges and levels.
// Assumes: Pins are asynchronous to mclk_i.
// Notes: Pulses are one cycle wide.

`timescale 1ns/1ps
`default_nettype none

module gpa_pin_detect #(
   parameter int NPIN = 4
) (
   // Clock and reset.
   input wire logic mclk_i,
   input wire logic resetn_i,
   // Pins and controls.
   input wire logic [NPIN-1:0] pin_i,
   input wire logic [NPIN-1:0] polarity_i,
   input wire logic [NPIN-1:0] enable_i,
   // Detection results.
   output logic [NPIN-1:0] edge_o,
   output logic [NPIN-1:0] level_o
);

   logic [NPIN-1:0] sync1;
   logic [NPIN-1:0] sync2;
   logic [NPIN-1:0] prev_act;
   wire [NPIN-1:0] act = ~(sync2 ^ polarity_i);

   if (NPIN < 1 || NPIN > 8) begin : gen_npin_check
      $error("NPIN must be 1 to 8.");
   end

   // ------------------------------------------------------------
   // Two-stage synchroniser and edge memory.
   // ------------------------------------------------------------
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         sync1 <= '0;
         sync2 <= '0;
         // Matches act just after reset, when sync2 and polarity_i are zero, so no false edge follows it.
         prev_act <= '1;
      end else begin
         sync1 <= pin_i;
         sync2 <= sync1;
         prev_act <= act;
      end
   end

   assign edge_o = act & ~prev_act & enable_i;
   assign level_o = act & enable_i;

endmodule

`default_nettype wire

/* testbench/gpa_port_assertions.sv */
// Purpose: Port-level checks for the port A pin control block.
// Assumes: Single clock domain, asynchronous active-low reset.
// Notes: Write-to-pad latency is two edges.
`timescale 1ns/1ps
`default_nettype none
module gpa_port_checker
   import gpa_pkg::*;
#(
   parameter int NPIN = 4
) (
   input wire logic mclk_i,
   input wire logic resetn_i,
   input wire logic [gpa_pkg::GPA_AW-1:0] addr_i,
   input wire logic [gpa_pkg::GPA_DW-1:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [gpa_pkg::GPA_DW-1:0] rdata_o,
   input wire logic [NPIN-1:0] pin_oe_o,
   input wire logic [NPIN-1:0] pull_en_o,
   input wire logic [NPIN-1:0] slew_en_o,
   input wire logic [NPIN-1:0] drive_high_o,
   input wire logic pin_irq_o,
   input wire logic irq_o
);
   // ------------------------------------------------------------
   // Properties.
   // ------------------------------------------------------------
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!resetn_i);
   property p_pull_off_out; pull_en_o & pin_oe_o |-> 1'b0; endproperty
   a_pull_off_out: assert property (p_pull_off_out) else $error("pull on output");
   property p_slew_in; (slew_en_o & ~pin_oe_o) != '0 |-> 1'b0; endproperty
   a_slew_in: assert property (p_slew_in) else $error("slew on input");
   property p_drive_in; (drive_high_o & ~pin_oe_o) != '0 |-> 1'b0; endproperty
   a_drive_in: assert property (p_drive_in) else $error("drive on input");
   property p_ack_zero; $past(rd_i) && $past(addr_i) == GPA_OFF_SC |-> !rdata_o[GPA_SC_ACK];
   endproperty
   a_ack_zero: assert property (p_ack_zero) else $error("ack read one");
   property p_ie_gate; wr_i && addr_i == GPA_OFF_SC && !wdata_i[GPA_SC_IE] |-> ##2 !pin_irq_o;
   endproperty
   a_ie_gate: assert property (p_ie_gate) else $error("request while disabled");
   property p_mask_gate; wr_i && addr_i == GPA_OFF_IMSK && wdata_i == 8'h00 |-> ##2 !irq_o;
   endproperty
   a_mask_gate: assert property (p_mask_gate) else $error("masked irq seen");
   property p_rst_zero; $rose(resetn_i) |-> pin_oe_o == '0 && pull_en_o == '0 && !irq_o;
   endproperty
   a_rst_zero: assert property (p_rst_zero) else $error("outputs not reset");
   property p_dir; wr_i && addr_i == GPA_OFF_DIR |-> ##2 pin_oe_o == $past(wdata_i[NPIN-1:0], 2);
   endproperty
   a_dir: assert property (p_dir) else $error("direction not applied");
   property p_pull; wr_i && addr_i == GPA_OFF_PULL
      |-> ##2 pull_en_o == ($past(wdata_i[NPIN-1:0], 2) & ~pin_oe_o); endproperty
   a_pull: assert property (p_pull) else $error("pull not applied");
endmodule
bind gpa_port gpa_port_checker #(.NPIN(NPIN)) chk_i (.mclk_i(mclk_i), .resetn_i(resetn_i),
   .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
   .pin_oe_o(pin_oe_o), .pull_en_o(pull_en_o), .slew_en_o(slew_en_o),
   .drive_high_o(drive_high_o), .pin_irq_o(pin_irq_o), .irq_o(irq_o));
`default_nettype wire

/* testbench/gpa_pin_model.sv */
// Purpose: External pin drivers and pad resolution for port A.
// Assumes: Pad drive wins, then external drive, then pull device.
// Notes: A floating pin toggles every cycle.
`timescale 1ns/1ps
`default_nettype none
module gpa_pin_model (
   input wire logic mclk_i,
   input wire logic [3:0] out_i,
   input wire logic [3:0] oe_i,
   input wire logic [3:0] pull_en_i,
   input wire logic [3:0] pull_up_i,
   input wire logic [3:0] ext_en_i,
   input wire logic [3:0] ext_lvl_i,
   output logic [3:0] pin_o
);
   // ------------------------------------------------------------
   // Pad resolution.
   // ------------------------------------------------------------
   logic flip = 1'b0;
   always @(posedge mclk_i) flip <= ~flip;
   assign pin_o = (oe_i & out_i) | (~oe_i & ext_en_i & ext_lvl_i)
      | (~oe_i & ~ext_en_i & pull_en_i & pull_up_i)
      | (~oe_i & ~ext_en_i & ~pull_en_i & {4{flip}});
endmodule
`default_nettype wire

/* testbench/test_port_a_pin_control_and_interrupt.sv */
// Purpose: Self-checking bench for the port A pin control block.
// Assumes: Register writes reach the pads two edges later.
// Notes: External drivers hold every pin, except pins 3 and 2 during t_pads.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
   $display("mismatch at %0t: got %h want %h", $time, g, e); end end
module test_port_a_pin_control_and_interrupt;
   import gpa_pkg::*;
   logic mclk_i = 1'b0, resetn_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
   logic [3:0] addr_i = 4'h0, ext_lvl = 4'h0, ext_en = 4'hF, pin_in_i, pin_out_o, pin_oe_o;
   logic [7:0] wdata_i = 8'h00, rdata_o;
   logic [3:0] pull_en_o, pull_up_o, slew_en_o, drive_high_o;
   logic pin_irq_o, irq_o;
   int n_errors = 0, n_checks = 0;
   gpa_port gpa_port_i (.mclk_i(mclk_i), .resetn_i(resetn_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pin_in_i(pin_in_i),
      .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o), .pull_en_o(pull_en_o),
      .pull_up_o(pull_up_o), .slew_en_o(slew_en_o), .drive_high_o(drive_high_o),
      .pin_irq_o(pin_irq_o), .irq_o(irq_o));
   gpa_pin_model gpa_pin_model_i (.mclk_i(mclk_i), .out_i(pin_out_o), .oe_i(pin_oe_o),
      .pull_en_i(pull_en_o), .pull_up_i(pull_up_o), .ext_en_i(ext_en), .ext_lvl_i(ext_lvl),
      .pin_o(pin_in_i));
   // ------------------------------------------------------------
   // Bus tasks and scenarios.
   // ------------------------------------------------------------
   initial begin
      forever #5 mclk_i = ~mclk_i;
   end
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge mclk_i) begin wr_i <= 1'b1; addr_i <= a; wdata_i <= d; end
      @(posedge mclk_i) wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge mclk_i) begin rd_i <= 1'b1; addr_i <= a; end
      @(posedge mclk_i) rd_i <= 1'b0;
      #1 `CHK(rdata_o, e)
   endtask
   task automatic t_reset();
      for (int i = 0; i < 16; i++) rd(4'(i), 8'h00);
   endtask
   task automatic t_reserved();
      for (int i = 2; i < 5; i++) begin
         wr(4'(i), 8'hFF);
         rd(4'(i), 8'h0F);
         wr(4'(i), 8'h00);
      end
   endtask
   task automatic t_pads();
      ext_en <= 4'h3;
      wr(GPA_OFF_DIR, 8'h03);
      wr(GPA_OFF_PULL, 8'h0F);
      wr(GPA_OFF_SLEW, 8'h0F);
      wr(GPA_OFF_DRIVE, 8'h0F);
      wr(GPA_OFF_POL, 8'h05);
      wr(GPA_OFF_DATA, 8'h02);
      repeat (2) @(posedge mclk_i);
      #1 `CHK(pull_en_o, 4'hC)
      `CHK(slew_en_o, 4'h3)
      `CHK(drive_high_o, 4'h3)
      `CHK(pin_oe_o, 4'h3)
      `CHK(pull_up_o, 4'hA)
      `CHK(pin_out_o, 4'h2)
      rd(GPA_OFF_DATA, 8'h0A);
      ext_en <= 4'hF;
      for (int i = 0; i < 5; i++) wr(4'(i), 8'h00);
   endtask
   task automatic t_edge();
      wr(GPA_OFF_POL, 8'h0F);
      wr(GPA_OFF_PSEL, 8'h01);
      wr(GPA_OFF_SC, 8'h06);
      ext_lvl <= 4'h2;
      repeat (6) @(posedge mclk_i);
      #1 `CHK(pin_irq_o, 1'b0)
      ext_lvl <= 4'h3;
      repeat (6) @(posedge mclk_i);
      #1 `CHK(pin_irq_o, 1'b1)
      wr(GPA_OFF_SC, 8'h0A);
      rd(GPA_OFF_SC, 8'h0A);
      wr(GPA_OFF_SC, 8'h00);
      rd(GPA_OFF_SC, 8'h08);
      `CHK(pin_irq_o, 1'b0)
      wr(GPA_OFF_SC, 8'h04);
      repeat (4) @(posedge mclk_i);
      rd(GPA_OFF_SC, 8'h00);
   endtask
   task automatic t_level();
      wr(GPA_OFF_IMSK, 8'h02);
      wr(GPA_OFF_SC, 8'h07);
      repeat (6) @(posedge mclk_i);
      rd(GPA_OFF_SC, 8'h0B);
      wr(GPA_OFF_SC, 8'h07);
      rd(GPA_OFF_SC, 8'h0B);
      rd(GPA_OFF_IST, 8'h03);
      `CHK(irq_o, 1'b1)
      wr(GPA_OFF_IMSK, 8'h00);
      rd(GPA_OFF_IMSK, 8'h00);
      `CHK(irq_o, 1'b0)
      ext_lvl <= 4'h2;
      repeat (6) @(posedge mclk_i);
      wr(GPA_OFF_SC, 8'h07);
      repeat (2) @(posedge mclk_i);
      rd(GPA_OFF_SC, 8'h03);
      wr(GPA_OFF_IST, 8'h03);
      rd(GPA_OFF_IST, 8'h00);
   endtask
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      #200000;
      n_errors++;
      tally_and_finish();
   end
   initial begin
      repeat (2) @(posedge mclk_i);
      resetn_i <= 1'b1;
      t_reset();
      t_reserved();
      t_pads();
      t_edge();
      t_level();
      tally_and_finish();
   end
endmodule
`default_nettype wire
